// [dv/adc_mode_control_sequencer_tb.sv]
// bench for the mode-control sequencer: modes, power states, readout
// assumes the master model drives the link on its own clock
`timescale 1ns/1ps
module adc_mode_control_sequencer_tb;
    logic        ref_clk = 1'b0;
    logic        arst_n = 1'b0;
    logic [15:0] conv_result = 16'hA5C3;
    logic        sclk, cs_n, sdi, sdo, conversion_done_strobe, sample_strobe;
    logic        osc_running, partial_power_down, full_power_down;
    logic        channel_defaults_load;
    logic [1:0]  conversion_method;
    int          fail_count = 0;
    int          n_compared = 0;
    int          n_smp = 0;
    int          n_dld = 0;
    int          s;
    always #4 ref_clk = ~ref_clk;
    always @(negedge ref_clk) begin
        n_smp += int'(sample_strobe === 1'b1);
        n_dld += int'(channel_defaults_load === 1'b1);
    end
    spi_master_model spi_master_model_inst (.sclk, .cs_n, .sdi, .sdo);
    adc_mode_control_sequencer adc_mode_control_sequencer_inst (.ref_clk,
        .arst_n, .sclk, .cs_n, .sdi, .sdo, .conversion_done_strobe,
        .conv_result, .sample_strobe, .osc_running, .partial_power_down,
        .full_power_down, .channel_defaults_load, .conversion_method);
    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task end_sim;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task mode(input logic [2:0] c);
        spi_master_model_inst.frame({1'b1, c, 4'h8}, 8);
    endtask
    task t_modes;
        chk(16'({partial_power_down, full_power_down}), 16'h0);
        chk(16'(conversion_method), 16'h0);
        mode(3'h1); chk(16'(conversion_method), 16'h1);
        mode(3'h3); chk(16'(conversion_method), 16'h1);
        mode(3'h5); chk(16'(conversion_method), 16'h1);
        mode(3'h2); chk(16'(conversion_method), 16'h2);
        mode(3'h6); spi_master_model_inst.glitch;
        chk(16'({partial_power_down, full_power_down}), 16'h2);
        mode(3'h7); spi_master_model_inst.glitch;
        chk(16'({partial_power_down, full_power_down}), 16'h1);
        mode(3'h6); chk(16'(full_power_down), 16'h0);
        s = n_dld;
        mode(3'h4);
        chk(16'({partial_power_down, full_power_down}), 16'h0);
        chk(16'(n_dld - s), 16'h1);
    endtask
    task t_ext;
        s = n_smp;
        spi_master_model_inst.frame(8'h80, 32);
        chk(spi_master_model_inst.rx[15:0], conv_result);
        chk(16'(n_smp - s), 16'h1);
        chk(16'(conversion_done_strobe), 16'h0);
    endtask
    task t_int;
        mode(3'h2);
        s = n_smp;
        spi_master_model_inst.frame(8'h80, 8);
        for (int i = 0; i < 2000 && conversion_done_strobe !== 1'b1; i++)
            @(negedge ref_clk);
        chk(16'(conversion_done_strobe), 16'h1);
        chk(16'(n_smp - s), 16'h1);
        spi_master_model_inst.frame(8'h00, 17);
        chk(spi_master_model_inst.rx[15:0], conv_result);
        chk(16'(conversion_done_strobe), 16'h1);
        mode(3'h2); chk(16'(conversion_done_strobe), 16'h0);
    endtask
    task t_acq;
        mode(3'h1);
        s = n_smp;
        spi_master_model_inst.frame(8'h80, 16);
        chk(16'(osc_running), 16'h1);
        for (int i = 0; i < 2000 && conversion_done_strobe !== 1'b1; i++)
            @(negedge ref_clk);
        chk(16'(n_smp - s), 16'h1);
        spi_master_model_inst.frame(8'h00, 17);
        chk(spi_master_model_inst.rx[15:0], conv_result);
    endtask
    initial begin
        repeat (3) @(negedge ref_clk);
        arst_n = 1'b1;
        repeat (4) @(negedge ref_clk);
        t_modes;
        t_ext;
        t_int;
        t_acq;
        end_sim;
    end
    initial begin
        #100000;
        fail_count++;
        end_sim;
    end
endmodule

// [dv/adc_mode_sva.sv]
// port assertions for the mode-control sequencer
// assumes it is bound to every sequencer instance
`timescale 1ns/1ps
module adc_mode_sva (
    // clock and reset
    input wire logic       ref_clk,
    input wire logic       arst_n,
    // watched ports
    input wire logic       cs_n,
    input wire logic       sdo,
    input wire logic       conversion_done_strobe,
    input wire logic       sample_strobe,
    input wire logic       osc_running,
    input wire logic       partial_power_down,
    input wire logic       full_power_down,
    input wire logic       channel_defaults_load,
    input wire logic [1:0] conversion_method
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    ext_strobe_low_a: assert property ((conversion_method == 2'h0)[*3]
        |-> !conversion_done_strobe) else $error("strobe high in mode 0");
    power_excl_a: assert property (!(partial_power_down
        && full_power_down)) else $error("both power-down levels set");
    defaults_apply_a: assert property ($rose(channel_defaults_load)
        |-> ##[0:4] (conversion_method == 2'h0 && !partial_power_down
        && !full_power_down)) else $error("defaults not restored");
    sample_pulse_a: assert property (sample_strobe
        |=> !sample_strobe) else $error("sample strobe too long");
    int_sample_a: assert property ($rose(osc_running)
        && conversion_method == 2'h2 |-> ##[250:340] sample_strobe)
        else $error("internal sample instant missed");
    strobe_cause_a: assert property ($rose(conversion_done_strobe)
        |-> conversion_method != 2'h0) else $error("strobe in mode 0");
    osc_cause_a: assert property ($rose(osc_running)
        |-> conversion_method != 2'h0 && !full_power_down)
        else $error("oscillator started wrongly");
    sdo_idle_a: assert property (cs_n[*2] |-> !sdo)
        else $error("sdo driven while deselected");
    ext_sample_cs_a: assert property (sample_strobe
        && conversion_method == 2'h0 |-> !cs_n)
        else $error("mode 0 sample outside frame");
endmodule
bind adc_mode_control_sequencer adc_mode_sva adc_mode_sva_inst (.ref_clk,
    .arst_n, .cs_n, .sdo, .conversion_done_strobe, .sample_strobe,
    .osc_running, .partial_power_down, .full_power_down,
    .channel_defaults_load, .conversion_method);

// [dv/spi_master_model.sv]
// serial master: frames of bytes on a 32 ns serial clock
// assumes the converter takes sdi on rising sclk, shifts sdo on falling
`timescale 1ns/1ps
module spi_master_model (
    // link
    output logic      sclk,
    output logic      cs_n,
    output logic      sdi,
    input  wire logic sdo
);
    logic [31:0] rx = 32'h0;
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi  = 1'b1;
    end
    // steady clock only inside frames; cs rises after last fall
    task frame(input logic [7:0] b, input int n);
        cs_n = 1'b0;
        #16;
        for (int i = 0; i < n; i++) begin
            sdi = (i < 8) ? b[7-i] : 1'b0;
            #16 sclk = 1'b1;
            rx = {rx[30:0], sdo};
            #16 sclk = 1'b0;
        end
        #16 cs_n = 1'b1;
        sdi = ~sdi;
        #200;
    endtask
    task glitch;
        cs_n = 1'b0;
        #10 cs_n = 1'b1;
        #100;
    endtask
endmodule

// [verilog/adc_mode_control_sequencer.sv]
// mode-control sequencer of a serial SAR converter: command decode,
// conversion timing in three methods, power states and result shift-out
// assumes the serial master owns sclk and cs_n; sdi and cs_n change
// away from the rising sclk edge; conv_result comes from the analog core
//
// Notes on behaviour
// - external clock mode samples on falling edge of serial cycle 14.
// - strobe output stays low throughout external clock mode.
// - first one after chip select falls is bit 7, framing the byte.
// - bits 6 to 4 form the three-bit mode select field.
// - codes: 0 ext clock, 1 ext acquisition, 2 internal, 4 reset, 6 partial power-down, 7 off.
// - external acquisition samples on falling edge 16, converts on oscillator.
// - strobe rises at conversion end, falls on next start bit edge.
// - internal oscillator starts 100 to 400 ns after falling edge 8.
// - internal clock mode samples on oscillator falling edge eleven.
// - reset code restores full power, external clock mode, channel defaults.
// - code six enters partial power-down.
// - partial power-down ends only on a complete non-partial mode byte.
// - code seven enters full power-down.
// - full power-down ends only on a complete non-full mode byte.
// - after reset the block is fully powered in external clock mode.
// - result goes out MSB first, changing on falling serial clock edges.
// - new start bit accepted mid-readout after mode-dependent bit count.
`timescale 1ns/1ps
module adc_mode_control_sequencer #(
    parameter int RES_W    = 16,
    parameter int CONV_OSC = 16
) (
    // system clock and reset
    input  wire logic             ref_clk,
    input  wire logic             arst_n,
    // serial link
    input  wire logic             sclk,
    input  wire logic             cs_n,
    input  wire logic             sdi,
    output logic                  sdo,
    output logic                  conversion_done_strobe,
    // analog core
    input  wire logic [RES_W-1:0] conv_result,
    output logic                  sample_strobe,
    output logic                  osc_running,
    output logic                  partial_power_down,
    output logic                  full_power_down,
    output logic                  channel_defaults_load,
    output logic [1:0]            conversion_method
);
    localparam int TM_W = adc_mode_pkg::TM_W;
    localparam int CNT_W = adc_mode_pkg::CNT_W;
    localparam int RC_W = $clog2(RES_W + 1);
    localparam logic [RC_W-1:0] RD_LAST = RC_W'(RES_W);
    localparam logic [TM_W-1:0] DLY_LAST =
        TM_W'(adc_mode_pkg::OSC_START_CYC - 1);
    localparam logic [TM_W-1:0] ACQ_LAST =
        TM_W'(adc_mode_pkg::INT_SAMPLE_OSC - 1);
    localparam logic [TM_W-1:0] CONV_LAST = TM_W'(CONV_OSC - 1);

    // frame flops are cleared while chip select is high
    logic frame_rst_n;
    assign frame_rst_n = arst_n & ~cs_n;

    // ---------------- sclk rising edge: command framing ----------------
    logic                    in_frame;
    logic [CNT_W-1:0]        bit_cnt;
    logic [6:0]              shreg;
    logic                    conv_cmd;
    adc_mode_pkg::method_t   method;
    adc_mode_pkg::power_t    power;
    logic                    clr_tgl;
    logic                    dflt_tgl;
    logic                    next_in_frame;
    logic [CNT_W-1:0]        next_bit_cnt;
    logic [6:0]              next_shreg;
    logic                    next_conv_cmd;
    adc_mode_pkg::method_t   next_method;
    adc_mode_pkg::power_t    next_power;
    logic                    next_clr_tgl;
    logic                    next_dflt_tgl;
    logic [7:0]              byte_now;
    logic [2:0]              sel;
    logic [CNT_W-1:0]        conv_end;
    logic [RC_W-1:0]         rd_cnt;
    logic                    rd_active;
    logic                    start_ok;
    logic [RC_W-1:0]         rd_ok;

    always_comb begin
        case (method)
            adc_mode_pkg::METH_EXT_ACQ: begin
                conv_end = adc_mode_pkg::ACQ_SAMPLE_CYC;
                rd_ok    = RC_W'(adc_mode_pkg::RD_OK_ACQ);
            end
            adc_mode_pkg::METH_INT_CLK: begin
                conv_end = adc_mode_pkg::INT_START_CYC;
                rd_ok    = RC_W'(adc_mode_pkg::RD_OK_INT);
            end
            default: begin
                conv_end = adc_mode_pkg::EXT_LOAD_CYC;
                rd_ok    = RC_W'(adc_mode_pkg::RD_OK_EXT);
            end
        endcase
    end

    assign start_ok = !rd_active || (rd_cnt >= rd_ok);

    always_comb begin
        next_in_frame = in_frame;
        next_bit_cnt  = bit_cnt;
        next_shreg    = shreg;
        next_conv_cmd = conv_cmd;
        next_method   = method;
        next_power    = power;
        next_clr_tgl  = clr_tgl;
        next_dflt_tgl = dflt_tgl;
        byte_now      = {shreg, sdi};
        sel           = byte_now[adc_mode_pkg::SEL_HI:adc_mode_pkg::SEL_LO];
        if (!in_frame) begin
            if (sdi && start_ok) begin
                next_in_frame = 1'b1;
                next_bit_cnt  = adc_mode_pkg::CNT_ONE;
                next_shreg    = 7'h01;
                next_clr_tgl  = ~clr_tgl;
            end
        end else begin
            if (bit_cnt != adc_mode_pkg::CNT_MAX) begin
                next_bit_cnt = bit_cnt + adc_mode_pkg::CNT_ONE;
            end
            if (bit_cnt < adc_mode_pkg::BYTE_LAST_CYC) begin
                next_shreg = byte_now[6:0];
            end
            if (bit_cnt == adc_mode_pkg::BYTE_LAST_CYC - CNT_W'(1)) begin
                next_in_frame = 1'b0;
                if (byte_now[adc_mode_pkg::TAIL_HI:0]
                        == adc_mode_pkg::MODE_TAIL) begin
                    case (sel)
                        adc_mode_pkg::SEL_EXT_CLK,
                        adc_mode_pkg::SEL_EXT_ACQ,
                        adc_mode_pkg::SEL_INT_CLK: begin
                            next_method = adc_mode_pkg::method_t'(sel[1:0]);
                            next_power  = adc_mode_pkg::PWR_FULL;
                        end
                        adc_mode_pkg::SEL_RESET: begin
                            next_method   = adc_mode_pkg::METH_EXT_CLK;
                            next_power    = adc_mode_pkg::PWR_FULL;
                            next_dflt_tgl = ~dflt_tgl;
                        end
                        adc_mode_pkg::SEL_PART_PD: begin
                            next_power = adc_mode_pkg::PWR_PARTIAL;
                        end
                        adc_mode_pkg::SEL_FULL_PD: begin
                            next_power = adc_mode_pkg::PWR_OFF;
                        end
                        default: begin
                            next_power = power;
                        end
                    endcase
                end else if ((byte_now[adc_mode_pkg::TAIL_HI:0]
                        == adc_mode_pkg::CONV_TAIL)
                        && (power == adc_mode_pkg::PWR_FULL)) begin
                    next_in_frame = 1'b1;
                    next_conv_cmd = 1'b1;
                end
            end
            if (conv_cmd && (bit_cnt == conv_end)) begin
                next_in_frame = 1'b0;
                next_conv_cmd = 1'b0;
            end
        end
    end

    // mode and power survive chip select; power-on defaults here
    always_ff @(posedge sclk or negedge arst_n) begin
        if (!arst_n) begin
            method   <= adc_mode_pkg::METH_EXT_CLK;
            power    <= adc_mode_pkg::PWR_FULL;
            clr_tgl  <= 1'b0;
            dflt_tgl <= 1'b0;
        end else begin
            method   <= next_method;
            power    <= next_power;
            clr_tgl  <= next_clr_tgl;
            dflt_tgl <= next_dflt_tgl;
        end
    end

    always_ff @(posedge sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            in_frame <= 1'b0;
            bit_cnt  <= '0;
            shreg    <= '0;
            conv_cmd <= 1'b0;
        end else begin
            in_frame <= next_in_frame;
            bit_cnt  <= next_bit_cnt;
            shreg    <= next_shreg;
            conv_cmd <= next_conv_cmd;
        end
    end

    // ---------------- sclk falling edge: sampling and shift-out --------
    logic             samp_tgl;
    logic             start_tgl;
    logic             rd_pending;
    logic [RES_W-1:0] out_sh;
    logic [RES_W-1:0] result_word;
    logic             next_samp_tgl;
    logic             next_start_tgl;
    logic             next_rd_pending;
    logic [RES_W-1:0] next_out_sh;
    logic [RC_W-1:0]  next_rd_cnt;
    logic             next_rd_active;
    logic             next_sdo;
    logic             conv_now;

    always_comb begin
        next_samp_tgl   = samp_tgl;
        next_start_tgl  = start_tgl;
        next_rd_pending = rd_pending;
        next_out_sh     = out_sh;
        next_rd_cnt     = rd_cnt;
        next_rd_active  = rd_active;
        next_sdo        = sdo;
        conv_now        = in_frame && conv_cmd;
        if (conv_now) begin
            case (method)
                adc_mode_pkg::METH_EXT_ACQ: begin
                    if (bit_cnt == adc_mode_pkg::ACQ_SAMPLE_CYC) begin
                        next_samp_tgl   = ~samp_tgl;
                        next_start_tgl  = ~start_tgl;
                        next_rd_pending = 1'b1;
                    end
                end
                adc_mode_pkg::METH_INT_CLK: begin
                    if (bit_cnt == adc_mode_pkg::INT_START_CYC) begin
                        next_start_tgl  = ~start_tgl;
                        next_rd_pending = 1'b1;
                    end
                end
                default: begin
                    if (bit_cnt == adc_mode_pkg::EXT_SAMPLE_CYC) begin
                        next_samp_tgl = ~samp_tgl;
                    end
                end
            endcase
        end
        if (conv_now && (method == adc_mode_pkg::METH_EXT_CLK)
                && (bit_cnt == adc_mode_pkg::EXT_LOAD_CYC)) begin
            next_out_sh    = conv_result;
            next_rd_cnt    = RC_W'(1);
            next_rd_active = 1'b1;
            next_sdo       = conv_result[RES_W-1];
        end else if (rd_pending && !in_frame) begin
            // word is stable: master reads only after the strobe rose
            next_rd_pending = 1'b0;
            next_out_sh     = result_word;
            next_rd_cnt     = RC_W'(1);
            next_rd_active  = 1'b1;
            next_sdo        = result_word[RES_W-1];
        end else if (rd_active) begin
            next_out_sh = {out_sh[RES_W-2:0], 1'b0};
            next_sdo    = out_sh[RES_W-2];
            if (rd_cnt == RD_LAST) begin
                next_rd_active = 1'b0;
                next_sdo       = 1'b0;
            end else begin
                next_rd_cnt = rd_cnt + RC_W'(1);
            end
        end
    end

    always_ff @(negedge sclk or negedge arst_n) begin
        if (!arst_n) begin
            samp_tgl   <= 1'b0;
            start_tgl  <= 1'b0;
            rd_pending <= 1'b0;
        end else begin
            samp_tgl   <= next_samp_tgl;
            start_tgl  <= next_start_tgl;
            rd_pending <= next_rd_pending;
        end
    end

    always_ff @(negedge sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            out_sh    <= '0;
            rd_cnt    <= '0;
            rd_active <= 1'b0;
            sdo       <= 1'b0;
        end else begin
            out_sh    <= next_out_sh;
            rd_cnt    <= next_rd_cnt;
            rd_active <= next_rd_active;
            sdo       <= next_sdo;
        end
    end

    // ---------------- ref_clk domain: timing and analog control --------
    logic [7:0] link_s;
    logic [3:0] tgl_d;
    logic [3:0] tgl_edge;
    // power and method cross as a word: taken once two samples agree
    logic [3:0] cfg;
    logic [3:0] cfg_d;
    logic [3:0] next_cfg;

    sync_2ff #(
        .W      (8)
    ) u_link_sync (
        .clk    (ref_clk),
        .arst_n (arst_n),
        .d      ({power, method, dflt_tgl, clr_tgl, start_tgl, samp_tgl}),
        .q      (link_s)
    );

    assign tgl_edge = link_s[3:0] ^ tgl_d;

    logic osc_fall;

    osc_div #(
        .HALF      (adc_mode_pkg::OSC_HALF_CYC)
    ) u_osc (
        .clk       (ref_clk),
        .arst_n    (arst_n),
        .run       (osc_running),
        .osc       (),
        .fall_tick (osc_fall)
    );

    adc_mode_pkg::conv_state_t state;
    adc_mode_pkg::conv_state_t next_state;
    logic [TM_W-1:0]  tm;
    logic [TM_W-1:0]  next_tm;
    logic [RES_W-1:0] next_result_word;
    logic             next_strobe;
    logic             next_sample;
    logic             done;

    always_comb begin
        next_state       = state;
        next_tm          = tm;
        next_result_word = result_word;
        next_sample      = tgl_edge[0];
        done             = 1'b0;
        next_cfg         = (link_s[7:4] == cfg_d) ? link_s[7:4] : cfg;
        case (state)
            adc_mode_pkg::ST_IDLE: begin
                if (tgl_edge[1]) begin
                    next_tm = '0;
                    if (cfg[1:0] == adc_mode_pkg::METH_INT_CLK) begin
                        next_state = adc_mode_pkg::ST_DELAY;
                    end else begin
                        next_state = adc_mode_pkg::ST_CONV;
                    end
                end
            end
            adc_mode_pkg::ST_DELAY: begin
                next_tm = tm + TM_W'(1);
                if (tm == DLY_LAST) begin
                    next_tm    = '0;
                    next_state = adc_mode_pkg::ST_ACQ;
                end
            end
            adc_mode_pkg::ST_ACQ: begin
                if (osc_fall) begin
                    next_tm = tm + TM_W'(1);
                    if (tm == ACQ_LAST) begin
                        next_tm     = '0;
                        next_sample = 1'b1;
                        next_state  = adc_mode_pkg::ST_CONV;
                    end
                end
            end
            adc_mode_pkg::ST_CONV: begin
                if (osc_fall) begin
                    next_tm = tm + TM_W'(1);
                    if (tm == CONV_LAST) begin
                        done             = 1'b1;
                        next_result_word = conv_result;
                        next_state       = adc_mode_pkg::ST_IDLE;
                    end
                end
            end
            default: begin
                next_state = adc_mode_pkg::ST_IDLE;
            end
        endcase
        next_strobe = conversion_done_strobe;
        if (tgl_edge[2]) begin
            next_strobe = 1'b0;
        end
        if (done) begin
            next_strobe = 1'b1;
        end
        if (cfg[1:0] == adc_mode_pkg::METH_EXT_CLK) begin
            next_strobe = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state                  <= adc_mode_pkg::ST_IDLE;
            tm                     <= '0;
            result_word            <= '0;
            tgl_d                  <= '0;
            cfg_d                  <= '0;
            cfg                    <= {adc_mode_pkg::PWR_FULL,
                                       adc_mode_pkg::METH_EXT_CLK};
            conversion_done_strobe <= 1'b0;
            sample_strobe          <= 1'b0;
            osc_running            <= 1'b0;
            partial_power_down     <= 1'b0;
            full_power_down        <= 1'b0;
            channel_defaults_load  <= 1'b0;
            conversion_method      <= adc_mode_pkg::METH_EXT_CLK;
        end else begin
            state                  <= next_state;
            tm                     <= next_tm;
            result_word            <= next_result_word;
            tgl_d                  <= link_s[3:0];
            cfg_d                  <= link_s[7:4];
            cfg                    <= next_cfg;
            conversion_done_strobe <= next_strobe;
            sample_strobe          <= next_sample;
            osc_running            <= (next_state == adc_mode_pkg::ST_ACQ)
                                   || (next_state == adc_mode_pkg::ST_CONV);
            partial_power_down     <=
                (cfg[3:2] == adc_mode_pkg::PWR_PARTIAL);
            full_power_down        <=
                (cfg[3:2] == adc_mode_pkg::PWR_OFF);
            channel_defaults_load  <= tgl_edge[3];
            conversion_method      <= cfg[1:0];
        end
    end
endmodule

// [verilog/adc_mode_pkg.sv]
// constants, codes and timing shared by the mode-control sequencer files
// assumes a 125 MHz ref_clk and a serial master that owns the serial clock
package adc_mode_pkg;

    // mode-control byte layout
    localparam int START_POS = 7;
    localparam int SEL_HI    = 6;
    localparam int SEL_LO    = 4;
    localparam int TAIL_HI   = 3;
    localparam logic [3:0] MODE_TAIL = 4'h8;
    localparam logic [3:0] CONV_TAIL = 4'h0;
    localparam int BYTE_BITS = 8;

    // mode select codes
    typedef enum logic [2:0] {
        SEL_EXT_CLK  = 3'h0,
        SEL_EXT_ACQ  = 3'h1,
        SEL_INT_CLK  = 3'h2,
        SEL_RSV_3    = 3'h3,
        SEL_RESET    = 3'h4,
        SEL_RSV_5    = 3'h5,
        SEL_PART_PD  = 3'h6,
        SEL_FULL_PD  = 3'h7
    } mode_sel_t;

    typedef enum logic [1:0] {
        METH_EXT_CLK = 2'h0,
        METH_EXT_ACQ = 2'h1,
        METH_INT_CLK = 2'h2
    } method_t;

    typedef enum logic [1:0] {
        PWR_FULL    = 2'h0,
        PWR_PARTIAL = 2'h1,
        PWR_OFF     = 2'h2
    } power_t;

    // serial clock cycle numbers, start bit is cycle 1
    localparam int CNT_W = 6;
    localparam logic [CNT_W-1:0] CNT_ONE        = 6'h01;
    localparam logic [CNT_W-1:0] CNT_MAX        = 6'h3F;
    localparam logic [CNT_W-1:0] EXT_SAMPLE_CYC = 6'h0E;
    localparam logic [CNT_W-1:0] EXT_LOAD_CYC   = 6'h10;
    localparam logic [CNT_W-1:0] ACQ_SAMPLE_CYC = 6'h10;
    localparam logic [CNT_W-1:0] INT_START_CYC  = 6'h08;
    localparam logic [CNT_W-1:0] BYTE_LAST_CYC  = 6'h08;

    // result bits that must be out before a new start bit is seen
    localparam int RD_W = 5;
    localparam logic [RD_W-1:0] RD_OK_EXT = 5'h0D;
    localparam logic [RD_W-1:0] RD_OK_ACQ = 5'h09;
    localparam logic [RD_W-1:0] RD_OK_INT = 5'h0C;

    // internal oscillator and its start delay
    localparam int REF_CLK_KHZ    = 125000;
    localparam int OSC_KHZ        = 4500;
    localparam int OSC_HALF_CYC   = (REF_CLK_KHZ + OSC_KHZ) / (2 * OSC_KHZ);
    localparam int OSC_START_NS   = 100;
    localparam int OSC_START_CYC  =
        (OSC_START_NS * REF_CLK_KHZ + 999999) / 1000000;
    localparam int INT_SAMPLE_OSC = 11;
    localparam int TM_W           = 8;

    // one-hot sequencer states in the ref_clk domain
    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_DELAY = 4'h2,
        ST_ACQ   = 4'h4,
        ST_CONV  = 4'h8
    } conv_state_t;

endpackage

// [verilog/osc_div.sv]
// internal conversion oscillator derived from ref_clk by a divider
// assumes run is a registered level; osc idles low while stopped
`timescale 1ns/1ps
module osc_div #(
    parameter int HALF = 14
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic arst_n,
    // control and ticks
    input  wire logic run,
    output logic      osc,
    output logic      fall_tick
);
    localparam int W = $clog2(HALF + 1);
    localparam logic [W-1:0] LAST = W'(HALF - 1);

    logic [W-1:0] cnt;
    logic [W-1:0] next_cnt;
    logic         next_osc;
    logic         next_fall_tick;

    always_comb begin
        next_cnt       = cnt;
        next_osc       = osc;
        next_fall_tick = 1'b0;
        if (!run) begin
            next_cnt = '0;
            next_osc = 1'b0;
        end else if (cnt == LAST) begin
            next_cnt       = '0;
            next_osc       = ~osc;
            next_fall_tick = osc;
        end else begin
            next_cnt = cnt + W'(1);
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt       <= '0;
            osc       <= 1'b0;
            fall_tick <= 1'b0;
        end else begin
            cnt       <= next_cnt;
            osc       <= next_osc;
            fall_tick <= next_fall_tick;
        end
    end
endmodule

// [verilog/sync_2ff.sv]
// two-flop synchroniser for a bundle of levels or toggles
// assumes each bit changes seldom enough to be seen on its own
`timescale 1ns/1ps
module sync_2ff #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         arst_n,
    // levels
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_q;

    always_comb begin
        next_meta = d;
        next_q    = meta;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= next_meta;
            q    <= next_q;
        end
    end
endmodule
